// *** rtl/dcd_map.svh ***
// register offsets, field positions, reset values and counts of the compare director
// What this block does
// - execute with clear-address decode zeroes the register file address counter when bit 15 is clear.
// - bit 15 set loads rf counter from bits 28-31, inverted word feeds count mux.
// - count mux passes bits 16-31 when select high, inverted rf bus when low.
// - bit 15 clear loads byte counter from the director count field at execute.
// - execute captures bit 6 (save) and bit 13 (mismatch qualifier) into holding bits.
// - execute sets compare-active: read in progress, length check, checkword, done logic.
// - held bit 6 enables half write enables, catching register onto bus; rf increments run without it.
// - bit 10 picks rf bus as compare source and disables buffer control.
// - execute presets byte control when bit 9 is one, preclears it otherwise.
// - execute clears compare done and compare condition not met.
// - count one, phase a: half select copies byte control.
// - half select clear presents upper compare byte, else lower byte.
// - count three, phase b: catch shift register; rank 4 full clear means lost data.
// - count four, phase a: byte ready, write caught byte to rf half, toggle control.
// - mismatch is inequality and held bit 13; sets not-met at count four.
// - count four decrements the byte counter by one each byte.
// - lower half with rank 4 full clears rank 4 full at count four.
// - counter at one before decrement: done, mismatch, completion, director done.
// - support director next: clear compare control, drop read, pulse read stop.
// - completion sets force eight-bit so shifting and counting run 8-bit.
// - count five clears byte ready; lower half increments the rf counter.
// - count not exhausted at count four repeats the byte from count one.
// - compare length comes from bits 16-31 or the index register at bits 28-31.
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCD_OFF_DIRECTOR 8'h00
`define DCD_OFF_CMD 8'h04
`define DCD_OFF_STATUS 8'h08
`define DCD_OFF_BUFFER 8'h0c
`define DCD_OFF_COUNT 8'h10
`define DCD_OFF_RF 8'h40
// ----------------------------------------
// director fields, msb is director bit 0
// ----------------------------------------
`define DCD_B_SAVE 25
`define DCD_B_SRC 21
`define DCD_B_CTRL 22
`define DCD_B_QUAL 18
`define DCD_B_FROM_RF 16
`define DCD_F_COUNT 15:0
`define DCD_F_LOC 3:0
// ----------------------------------------
// command and status bits
// ----------------------------------------
`define DCD_C_EXEC 0
`define DCD_C_CLR 1
`define DCD_C_SUPPORT 2
`define DCD_S_DONE 11
`define DCD_S_NOTMET 12
`define DCD_S_COMPL 3
// ----------------------------------------
// reset values and bit counts
// ----------------------------------------
`define DCD_RST_DIRECTOR 32'h0000_0000
`define DCD_RST_FORCE8 1'b1
`define DCD_CT_ONE 3'h1
`define DCD_CT_THREE 3'h3
`define DCD_CT_FOUR 3'h4
`define DCD_CT_FIVE 3'h5
`define DCD_CT_TOP8 3'h7
`define DCD_CT_TOP6 3'h5
`endif

// *** rtl/dcd_pkg.sv ***
// types of the compare director
package dcd_pkg;
  typedef logic [15:0][15:0] dcd_rf_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pend_rd;
    logic pend_wr;
    logic [7:0] addr;
    logic [31:0] director;
    logic next_support;
    logic [15:0] buf_word;
    logic rank_full;
    dcd_rf_t rf;
    logic [3:0] rf_addr;
    logic [15:0] byte_cnt;
    logic load_from_rf;
    logic save;
    logic qual;
    logic source_sel;
    logic buf_en;
    logic byte_ctrl;
    logic lower;
    logic active;
    logic done;
    logic not_met;
    logic mism_ind;
    logic lost;
    logic fault;
    logic completion;
    logic write_done;
    logic addr_exec;
    logic force8;
    logic byte_ready;
    logic [2:0] bit_cnt;
    logic clk_prev;
    logic [7:0] shreg;
    logic [7:0] catch_byte;
    logic director_done;
    logic read_stop;
  } dcd_state_t;
endpackage : dcd_pkg

// *** rtl/dcd_sync.sv ***
// two-stage synchroniser for pins from the drive
`timescale 1ns/100ps
module dcd_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dcd_sync_state_t;
  dcd_sync_state_t s;
  dcd_sync_state_t next_s;
  // first stage feeds only the second
  always_comb
  begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end
  assign q = s.s2;
endmodule : dcd_sync

// *** rtl/dcd_compare.sv ***
// compare director core with ahb-lite register slave
`timescale 1ns/100ps
`include "dcd_map.svh"
module dcd_compare
  import dcd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic read_clock_pin,
  input wire logic read_data_pin,
  output logic read_in_progress,
  output logic read_stop_pulse,
  output logic director_done,
  output logic completion_status,
  output logic fault,
  output logic mismatch_indication,
  output logic buffer_ctrl_enable
);
  dcd_state_t s;
  dcd_state_t next_s;
  logic clk_s;
  logic dat_s;
  logic phase_a;
  logic phase_b;
  logic run;
  logic step1;
  logic step3;
  logic step4;
  logic step5;
  logic exec;
  logic wr_buf;
  logic count_mux_select;
  logic [15:0] count_mux;
  logic [15:0] cmp_word;
  logic [7:0] cmp_byte;
  logic compare_inequality;
  logic mismatch;
  logic [2:0] top;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  dcd_sync #(.W(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({read_clock_pin, read_data_pin}),
    .q({clk_s, dat_s})
  );

  // ----------------------------------------
  // derived terms
  // ----------------------------------------
  assign phase_a = clk_s & ~s.clk_prev;
  assign phase_b = ~clk_s & s.clk_prev;
  // done freezes the byte loop until the next execute
  assign run = s.active & ~s.done;
  assign step1 = run & phase_a & (s.bit_cnt == `DCD_CT_ONE);
  assign step3 = run & phase_b & (s.bit_cnt == `DCD_CT_THREE);
  assign step4 = run & phase_a & (s.bit_cnt == `DCD_CT_FOUR);
  assign step5 = run & phase_a & (s.bit_cnt == `DCD_CT_FIVE);
  assign top = s.force8 ? `DCD_CT_TOP8 : `DCD_CT_TOP6;
  assign exec = s.pend_wr & (s.addr == `DCD_OFF_CMD) & hwdata[`DCD_C_EXEC];
  assign wr_buf = s.pend_wr & (s.addr == `DCD_OFF_BUFFER);
  assign count_mux_select = ~s.director[`DCD_B_FROM_RF];
  assign count_mux = count_mux_select ? s.director[`DCD_F_COUNT]
                                      : ~s.rf[s.director[`DCD_F_LOC]];
  assign cmp_word = s.source_sel ? s.rf[s.rf_addr] : s.buf_word;
  assign cmp_byte = s.lower ? cmp_word[7:0] : cmp_word[15:8];
  assign compare_inequality = (s.catch_byte != cmp_byte);
  assign mismatch = compare_inequality & s.qual;

  function automatic logic [31:0] dcd_read(input dcd_state_t st);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (st.addr[7:6] == `DCD_OFF_RF >> 6)
      v = {16'h0000, st.rf[st.addr[5:2]]};
    else
    begin
      unique case (st.addr)
        `DCD_OFF_DIRECTOR: v = st.director;
        `DCD_OFF_CMD: v = {29'h0000_0000, st.next_support, 2'h0};
        `DCD_OFF_STATUS: v = {16'h0000, st.source_sel, st.load_from_rf, st.rank_full,
                              st.not_met, st.done, st.lower, st.byte_ready, st.addr_exec,
                              st.force8, st.write_done, st.fault, st.lost, st.completion,
                              2'h0, st.active};
        `DCD_OFF_BUFFER: v = {15'h0000, st.rank_full, st.buf_word};
        `DCD_OFF_COUNT: v = {12'h000, st.rf_addr, st.byte_cnt};
        default: v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction : dcd_read

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.director_done = 1'b0;
    next_s.read_stop = 1'b0;
    next_s.clk_prev = clk_s;
    // link side: shift and count on the recovered phases
    if (phase_a)
      next_s.shreg = {s.shreg[6:0], dat_s};
    if (phase_b)
      next_s.bit_cnt = (s.bit_cnt == top) ? 3'h0 : s.bit_cnt + 3'h1;
    if (step1)
    begin
      next_s.lower = s.byte_ctrl;
      next_s.load_from_rf = 1'b0;
    end
    if (step3)
    begin
      next_s.catch_byte = s.shreg;
      if (!s.rank_full)
      begin
        next_s.lost = 1'b1;
        next_s.fault = 1'b1;
        next_s.completion = 1'b1;
        next_s.active = 1'b0;
        next_s.addr_exec = 1'b0;
      end
    end
    if (step4)
    begin
      next_s.byte_ready = 1'b1;
      if (s.save)
      begin
        // caught byte lands in the half picked at count one
        if (s.lower)
          next_s.rf[s.rf_addr][7:0] = s.catch_byte;
        else
          next_s.rf[s.rf_addr][15:8] = s.catch_byte;
      end
      next_s.byte_ctrl = ~s.byte_ctrl;
      if (mismatch)
        next_s.not_met = 1'b1;
      next_s.byte_cnt = s.byte_cnt - 16'h0001;
      if (s.lower && s.rank_full)
        next_s.rank_full = 1'b0;
      if (s.byte_cnt == 16'h0001)
      begin
        next_s.done = 1'b1;
        next_s.mism_ind = s.not_met | mismatch;
        next_s.completion = 1'b1;
        next_s.director_done = 1'b1;
        next_s.write_done = 1'b1;
        next_s.addr_exec = 1'b0;
        next_s.force8 = 1'b1;
        if (s.next_support)
        begin
          next_s.active = 1'b0;
          next_s.read_stop = 1'b1;
        end
      end
    end
    // otherwise the loop returns to count one on its own
    if (step5)
    begin
      next_s.byte_ready = 1'b0;
      if (s.lower)
        next_s.rf_addr = s.rf_addr + 4'h1;
    end
    // bus side: a read waits one cycle so hrdata comes from a flop
    next_s.pend_rd = 1'b0;
    next_s.pend_wr = 1'b0;
    if (s.pend_rd)
    begin
      next_s.hrdata = dcd_read(s);
      next_s.hreadyout = 1'b1;
    end
    if (s.pend_wr)
    begin
      if (s.addr[7:6] == `DCD_OFF_RF >> 6)
        next_s.rf[s.addr[5:2]] = hwdata[15:0];
      else if (s.addr == `DCD_OFF_DIRECTOR)
        next_s.director = hwdata;
    end
    // a fresh buffer word wins over a release in the same cycle
    if (wr_buf)
    begin
      next_s.buf_word = hwdata[15:0];
      next_s.rank_full = 1'b1;
    end
    if (exec)
    begin
      next_s.next_support = hwdata[`DCD_C_SUPPORT];
      if (hwdata[`DCD_C_CLR])
        next_s.rf_addr = 4'h0;
      if (s.director[`DCD_B_FROM_RF])
      begin
        next_s.rf_addr = s.director[`DCD_F_LOC];
        next_s.load_from_rf = 1'b1;
      end
      else
        next_s.load_from_rf = 1'b0;
      next_s.byte_cnt = count_mux;
      next_s.save = s.director[`DCD_B_SAVE];
      next_s.qual = s.director[`DCD_B_QUAL];
      next_s.source_sel = s.director[`DCD_B_SRC];
      next_s.buf_en = ~s.director[`DCD_B_SRC];
      next_s.byte_ctrl = s.director[`DCD_B_CTRL];
      // execute lands past count one, so the first byte takes its half here
      next_s.lower = s.director[`DCD_B_CTRL];
      next_s.done = 1'b0;
      next_s.not_met = 1'b0;
      next_s.mism_ind = 1'b0;
      next_s.active = 1'b1;
      next_s.addr_exec = 1'b1;
      next_s.lost = 1'b0;
      next_s.fault = 1'b0;
      next_s.completion = 1'b0;
      next_s.write_done = 1'b0;
      next_s.byte_ready = 1'b0;
    end
    if (hsel && htrans[1] && hready)
    begin
      next_s.addr = haddr[7:0];
      next_s.pend_wr = hwrite;
      next_s.pend_rd = ~hwrite;
      if (!hwrite)
        next_s.hreadyout = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.director <= `DCD_RST_DIRECTOR;
      s.buf_en <= 1'b1;
      s.force8 <= `DCD_RST_FORCE8;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign read_in_progress = s.active;
  assign read_stop_pulse = s.read_stop;
  assign director_done = s.director_done;
  assign completion_status = s.completion;
  assign fault = s.fault;
  assign mismatch_indication = s.mism_ind;
  assign buffer_ctrl_enable = s.buf_en;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking dcd_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  exec_clear_a: assert property (exec && hwdata[`DCD_C_CLR] && !s.director[`DCD_B_FROM_RF] |=> s.rf_addr == 4'h0) else $error("rf address not cleared");
  rf_count_a: assert property (exec && s.director[`DCD_B_FROM_RF] |=> s.byte_cnt == $past(count_mux) && s.load_from_rf) else $error("count not from inverted rf");
  count_load_a: assert property (exec && !s.director[`DCD_B_FROM_RF] |=> s.byte_cnt == $past(s.director[15:0])) else $error("count not from director");
  hold_bits_a: assert property (exec |=> s.save == $past(s.director[`DCD_B_SAVE]) && s.qual == $past(s.director[`DCD_B_QUAL])) else $error("holding bits wrong");
  active_set_a: assert property (exec |=> read_in_progress && !s.done && !s.not_met) else $error("execute setup wrong");
  src_sel_a: assert property (buffer_ctrl_enable != s.source_sel) else $error("buffer control not opposite source");
  ctrl_preset_a: assert property (exec |=> s.byte_ctrl == $past(s.director[`DCD_B_CTRL])) else $error("byte control preset wrong");
  half_copy_a: assert property (step1 && !exec |=> s.lower == $past(s.byte_ctrl)) else $error("half select not copied");
  lost_data_a: assert property (step3 && !s.rank_full && !exec |=> s.fault && completion_status && !read_in_progress) else $error("lost data missed");
  toggle_dec_a: assert property (step4 && !exec |=> s.byte_ctrl != $past(s.byte_ctrl) && s.byte_cnt == $past(s.byte_cnt) - 16'h0001) else $error("count four step wrong");
  not_met_a: assert property (step4 && mismatch && !exec |=> s.not_met) else $error("mismatch not latched");
  release_a: assert property (step4 && s.lower && s.rank_full && !wr_buf && !exec |=> !s.rank_full) else $error("rank not released");
  done_seq_a: assert property (step4 && s.byte_cnt == 16'h0001 && !exec |=> s.done && director_done && s.force8 ##1 !director_done) else $error("completion wrong");
  support_a: assert property (step4 && s.byte_cnt == 16'h0001 && s.next_support && !exec |=> !read_in_progress && read_stop_pulse) else $error("read not stopped");
  rf_inc_a: assert property (step5 && s.lower && !exec |=> s.rf_addr == $past(s.rf_addr) + 4'h1 && !s.byte_ready) else $error("rf counter not advanced");

  done_c: cover property (director_done && !mismatch_indication);
  mism_c: cover property (director_done ##1 mismatch_indication);
  lost_c: cover property (step3 && !s.rank_full);
  save_c: cover property (step4 && s.save && s.lower);
endmodule : dcd_compare

// *** tb/dcd_drive_model.sv ***
// read channel of the selected drive: serial clock and data
`timescale 1ns/100ps
module dcd_drive_model (
  output logic read_clock_pin,
  output logic read_data_pin
);
  // ----------------------------------------
  // serial frames
  // ----------------------------------------
  initial
  begin
    read_clock_pin = 1'b0;
    read_data_pin = 1'b0;
  end
  // top n bits of b, msb first, 160 ns a bit; clock rests high between frames
  task send(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      #80 read_clock_pin = 1'b0;
      read_data_pin = b[i];
      #80 read_clock_pin = 1'b1;
    end
    // released line flips so a stale bit never passes for data
    #80 read_data_pin = ~read_data_pin;
  endtask : send
endmodule : dcd_drive_model

// *** tb/disk_compare_director_tb.sv ***
// self-checking bench of the compare director
`timescale 1ns/100ps
`include "dcd_map.svh"
module disk_compare_director_tb;
  localparam logic [31:0] SAVE = 32'h1 << `DCD_B_SAVE;
  localparam logic [31:0] SRC = 32'h1 << `DCD_B_SRC;
  localparam logic [31:0] CTRL = 32'h1 << `DCD_B_CTRL;
  localparam logic [31:0] QUAL = 32'h1 << `DCD_B_QUAL;
  localparam logic [31:0] FROM_RF = 32'h1 << `DCD_B_FROM_RF;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic read_clock_pin, read_data_pin, read_in_progress, read_stop_pulse;
  logic director_done, completion_status, fault, mismatch_indication, buffer_ctrl_enable;
  int fail_count, samples_checked, done_seen, stop_seen;
  assign hready = hreadyout;
  dcd_compare dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .read_clock_pin(read_clock_pin), .read_data_pin(read_data_pin),
    .read_in_progress(read_in_progress), .read_stop_pulse(read_stop_pulse),
    .director_done(director_done), .completion_status(completion_status),
    .fault(fault), .mismatch_indication(mismatch_indication),
    .buffer_ctrl_enable(buffer_ctrl_enable));
  dcd_drive_model drive_u (.read_clock_pin(read_clock_pin), .read_data_pin(read_data_pin));
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ----------------------------------------
  // pulse counters and checks
  // ----------------------------------------
  always @(posedge hclk)
  begin
    if (director_done === 1'b1) done_seen++;
    if (read_stop_pulse === 1'b1) stop_seen++;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // bus master
  // ----------------------------------------
  // ready and read data are looked at mid-cycle, settled, before the edge that takes them
  task wait_rdy;
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(negedge hclk);
      n++;
    end
    if (n == 50) chk("hreadyout", 32'h1, 32'h0);
    rd = hrdata;
    @(posedge hclk);
  endtask : wait_rdy
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdc
  // buffer word, director, command, then two bytes; the byte left in the
  // shift register by the previous frame is compared first
  task cmp(input logic [15:0] bw, input logic [31:0] dir, input logic [2:0] cmd,
    input logic [7:0] b1, input logic [7:0] b2);
    wr(`DCD_OFF_BUFFER, {16'h0, bw});
    wr(`DCD_OFF_DIRECTOR, dir);
    wr(`DCD_OFF_CMD, {29'h0, cmd});
    repeat (2) @(posedge hclk);
    chk("read_in_progress", 32'h1, {31'h0, read_in_progress});
    drive_u.send(b1, 8);
    drive_u.send(b2, 8);
    repeat (10) @(posedge hclk);
  endtask : cmp
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fail_count = 0;
    samples_checked = 0;
    done_seen = 0;
    stop_seen = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("reset outputs", 32'h1, {25'h0, read_in_progress, read_stop_pulse, director_done,
      completion_status, fault, mismatch_indication, buffer_ctrl_enable});
    rdc("status reset", `DCD_OFF_STATUS, 32'h80);
    rdc("unmapped", 8'h20, 32'h0);
    wr(`DCD_OFF_STATUS, 32'hffff_ffff);
    rdc("status read only", `DCD_OFF_STATUS, 32'h80);
    wr(`DCD_OFF_DIRECTOR, 32'h1234_5678);
    rdc("director", `DCD_OFF_DIRECTOR, 32'h1234_5678);
    // lead-in puts byte boundaries in step with the bit counter
    drive_u.send(8'h00, 4);
    drive_u.send(8'ha5, 8);
    cmp(16'ha55a, QUAL | 32'h2, 3'b011, 8'h5a, 8'h0f);
    chk("done pulses", 32'h1, done_seen);
    chk("mismatch", 32'h0, {31'h0, mismatch_indication});
    chk("completion", 32'h1, {31'h0, completion_status});
    bus(1'b0, `DCD_OFF_STATUS, 32'h0);
    chk("status flags", 32'h0888, rd & 32'h3888);
    rdc("count", `DCD_OFF_COUNT, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      cmp(16'h0ff0, 32'h1 | (i[0] ? QUAL : 32'h0) | (i[1] ? CTRL : 32'h0), 3'b001,
        8'h0f, 8'h0f);
      chk("mismatch", {31'h0, i[0] & i[1]}, {31'h0, mismatch_indication});
      chk("done pulses", 32'(2 + i), done_seen);
    end
    wr(`DCD_OFF_RF + 8'h0c, 32'h0000_fffd);
    cmp(16'h0000, FROM_RF | SAVE | SRC | 32'h3, 3'b001, 8'hc3, 8'h55);
    chk("buffer enable", 32'h0, {31'h0, buffer_ctrl_enable});
    rdc("saved word", `DCD_OFF_RF + 8'h0c, 32'h0000_0fc3);
    rdc("count from rf", `DCD_OFF_COUNT, 32'h0003_0000);
    wr(`DCD_OFF_RF, 32'h0000_5511);
    wr(`DCD_OFF_RF + 8'h04, 32'h0000_2200);
    cmp(16'h0000, SRC | QUAL | 32'h3, 3'b011, 8'h11, 8'h99);
    drive_u.send(8'h00, 8);
    repeat (10) @(posedge hclk);
    chk("fault", 32'h1, {31'h0, fault});
    chk("completion", 32'h1, {31'h0, completion_status});
    chk("mismatch", 32'h0, {31'h0, mismatch_indication});
    chk("done pulses", 32'h6, done_seen);
    rdc("count after loss", `DCD_OFF_COUNT, 32'h0001_0001);
    cmp(16'h0000, 32'h1, 3'b101, 8'h00, 8'h00);
    chk("stop pulses", 32'h1, stop_seen);
    chk("read_in_progress", 32'h0, {31'h0, read_in_progress});
    chk("fault", 32'h0, {31'h0, fault});
    chk("done pulses", 32'h7, done_seen);
    rdc("command", `DCD_OFF_CMD, 32'h4);
    end_sim;
  end
  // a hang is cut short well after the roughly 1500 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    end_sim;
  end
endmodule : disk_compare_director_tb
